/* core/iox_expander.sv */
// Eight-bit port expander behind a two-wire serial slave, with a pin
// compare that raises an open-drain interrupt.
// Assumes the serial lines are already synchronous to clock_in and that
// the clock runs far faster than the serial clock: each serial clock phase
// must span at least four system clocks, and data may only move while the
// serial clock is low, at least two system clocks clear of either edge.
// Both open-drain outputs need an external pull-up to read high.
`include "iox_defines.svh"
`default_nettype none

module iox_expander
  import iox_pkg::*;
(
  // Clock and reset.
  input  wire logic       clock_in,
  input  wire logic       nrst_in,
  // Address straps.
  input  wire logic [2:0] addr_sel_in,
  // Serial bus lines.
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  // Port pins.
  input  wire logic [7:0] port_in,
  output logic [7:0]      port_out,
  output logic [7:0]      port_oe_out,
  // Open-drain interrupt.
  output logic            int_n_out,
  output logic            int_oe_out
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations.

  // Sequencer state and the previous sample of the bus lines.
  iox_state_e state;
  iox_bus_s   bus_q;
  // Byte assembly: bit count, receive shifter and transmit shifter.
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic       rd_nwr;
  logic       first_byte;
  logic       more;
  // Register file: pointer, direction (one means input) and input snapshot.
  logic [7:0] ptr;
  logic [7:0] dir;
  logic [7:0] in_reg;
  // Decoded bus events, each valid for one system clock.
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       byte_done;
  logic       read_go;
  logic [7:0] next_tx;

  // Selects the byte returned for a read at the given pointer.
  function automatic logic [7:0] rd_sel(input logic [7:0] p,
                                        input logic [7:0] pins,
                                        input logic [7:0] o,
                                        input logic [7:0] d);
    case (p)
      `IOX_PTR_INPUT:  rd_sel = pins;
      `IOX_PTR_OUTPUT: rd_sel = o;
      `IOX_PTR_DIR:    rd_sel = d;
      default:         rd_sel = 8'h00;
    endcase
  endfunction : rd_sel

  // True once all eight bits of a byte have been clocked in or out.
  function automatic logic byte_full(input logic [3:0] cnt);
    byte_full = (cnt == `IOX_BYTE_BITS);
  endfunction : byte_full

  //////////////////////////////////////////////////////////////////////////
  // Bus event decode.

  // Previous sample of both lines, for edge and condition detection.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_q <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      bus_q <= '{scl: scl_in, sda: sda_in};
    end
  end

  // Start and stop are data edges while the clock stays high.
  assign scl_rise   = scl_in & ~bus_q.scl;
  assign scl_fall   = ~scl_in & bus_q.scl;
  assign start_cond = scl_in & bus_q.scl & bus_q.sda & ~sda_in;
  assign stop_cond  = scl_in & bus_q.scl & ~bus_q.sda & sda_in;

  // A byte counts only once all eight bits were clocked in.
  assign byte_done = (state == IOX_WRITE) && scl_fall && byte_full(bit_cnt);

  // A read byte is loaded at the falling edge that ends an acknowledge.
  assign read_go = scl_fall && (((state == IOX_ACK_ADDR) && rd_nwr)
                   || ((state == IOX_ACK_READ) && more));
  assign next_tx = rd_sel(ptr, port_in, port_out, dir);

  //////////////////////////////////////////////////////////////////////////
  // Serial slave sequencer.

  // A transfer runs start, address, acknowledge, then bytes with their own
  // acknowledge slots until a stop or a repeated start. Start and stop are
  // checked ahead of the state decode so that either one cuts any byte in
  // flight: a byte cut short never reaches its acknowledge and never
  // updates a register. The bit count runs up on each rising serial clock
  // and is tested on the falling one, so a byte is whole only when the
  // eighth bit has been sampled and its clock low phase has begun.
  // Reset and a stop return the sequencer to idle.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state      <= IOX_IDLE;
      bit_cnt    <= 4'h0;
      shift      <= 8'h00;
      tx         <= 8'h00;
      rd_nwr     <= 1'b0;
      first_byte <= 1'b0;
      more       <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (start_cond) begin
      // Every start, repeated or not, expects a full address next.
      state      <= IOX_ADDR;
      bit_cnt    <= 4'h0;
      sda_oe_out <= 1'b0;
    end else if (stop_cond) begin
      // Nothing more is accepted until a new start.
      state      <= IOX_IDLE;
      sda_oe_out <= 1'b0;
    end else begin
      case (state)
        // Silent until the next start.
        IOX_IDLE: begin
          sda_oe_out <= 1'b0;
        end
        // Shift in seven address bits and the direction bit; answer only to
        // our own address so that other devices can share the bus.
        IOX_ADDR: begin
          if (scl_rise) begin
            shift   <= {shift[6:0], sda_in};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && byte_full(bit_cnt)) begin
            if (shift[7:1] == {`IOX_ADDR_HI, addr_sel_in}) begin
              rd_nwr     <= shift[0];
              sda_oe_out <= 1'b1;
              state      <= IOX_ACK_ADDR;
            end else begin
              state <= IOX_IDLE; // Foreign address: stay silent.
            end
          end
        end
        // Hold the acknowledge through one clock, then either put out the
        // first read bit or get ready for the pointer byte.
        IOX_ACK_ADDR: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (rd_nwr) begin
              tx         <= next_tx;
              sda_oe_out <= ~next_tx[7];
              state      <= IOX_READ;
            end else begin
              first_byte <= 1'b1;
              sda_oe_out <= 1'b0;
              state      <= IOX_WRITE;
            end
          end
        end
        // Collect a written byte; the first after the address is the pointer.
        IOX_WRITE: begin
          if (scl_rise) begin
            shift   <= {shift[6:0], sda_in};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            sda_oe_out <= 1'b1; // Acknowledge only a whole byte.
            state      <= IOX_ACK_WRITE;
          end
        end
        // Release the acknowledge at the end of its clock.
        IOX_ACK_WRITE: begin
          if (scl_fall) begin
            first_byte <= 1'b0;
            bit_cnt    <= 4'h0;
            sda_oe_out <= 1'b0;
            state      <= IOX_WRITE;
          end
        end
        // Pull each bit low or release it, moving on only after a falling edge
        // so the master never sees the data change while the clock is high.
        IOX_READ: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (byte_full(bit_cnt)) begin
              sda_oe_out <= 1'b0; // Let the master acknowledge.
              state      <= IOX_ACK_READ;
            end else begin
              tx         <= {tx[6:0], 1'b0};
              sda_oe_out <= ~tx[6];
            end
          end
        end
        // A master acknowledge asks for another copy of the same register; no
        // acknowledge ends our drive until the next start.
        IOX_ACK_READ: begin
          if (scl_rise) begin
            more <= ~sda_in;
          end else if (scl_fall) begin
            if (more) begin
              bit_cnt    <= 4'h0;
              tx         <= next_tx;
              sda_oe_out <= ~next_tx[7];
              state      <= IOX_READ;
            end else begin
              state <= IOX_IDLE; // Master declined; wait for stop.
            end
          end
        end
        default: begin
          state      <= IOX_IDLE;
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // The data line is only ever pulled low.
  // Keeping the value a constant flop means the pin can never fight the
  // pull-up: only the enable moves.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Port registers.

  // The first written byte sets the pointer, later ones the register.
  // Writes to the input register are dropped: it follows the pins only.
  // No auto-increment: every data byte lands at the same pointer, which
  // keeps repeated updates of one register cheap for the master.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ptr         <= `IOX_PTR_RST;
      port_out    <= `IOX_OUT_RST;
      dir         <= `IOX_DIR_RST;  // All pins inputs.
      port_oe_out <= ~`IOX_DIR_RST;
    end else if (byte_done) begin
      if (first_byte) begin
        ptr <= shift;
      end else if (ptr == `IOX_PTR_OUTPUT) begin
        port_out <= shift; // Only after a complete byte.
      end else if (ptr == `IOX_PTR_DIR) begin
        dir         <= shift;
        port_oe_out <= ~shift;
      end
    end
  end

  // Snapshot the pins on a port read or a stop; either clears a mismatch.
  // The byte sent and the snapshot are the same sample, so nothing is lost.
  // A stop clears a pending interrupt even outside our own transfer; a
  // later pin change raises it again.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      in_reg <= `IOX_IN_RST;
    end else if (read_go && (ptr == `IOX_PTR_INPUT)) begin
      in_reg <= port_in;
    end else if (stop_cond) begin
      in_reg <= port_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt.

  // The compare is registered so the interrupt pin comes straight from a
  // flop; this costs one clock of latency, far below a serial bit time.
  // Continuous compare of input pins only; a pin that returns to its
  // captured value drops out of the mismatch on its own.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      int_oe_out <= 1'b0;
    end else begin
      int_oe_out <= |((port_in ^ in_reg) & dir);
    end
  end

  // Open-drain level: low when enabled, never driven high.
  // The enable alone carries the interrupt state.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      int_n_out <= 1'b0;
    end else begin
      int_n_out <= 1'b0;
    end
  end

endmodule : iox_expander

`default_nettype wire

/* dv/iox_expander_checker.sv */
// Port-level assertions for the expander core.
// Assumes binding to iox_expander; sees only its ports.
`default_nettype none

module iox_expander_checker (
  input wire logic       clock_in,
  input wire logic       nrst_in,
  input wire logic [2:0] addr_sel_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic [7:0] port_in,
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_oe_out,
  input wire logic       int_n_out,
  input wire logic       int_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  // Defaults after any reset, and the first compare against all ones.
  a_reset_ports: assert property ($rose(nrst_in) |-> port_out == 8'hFF && port_oe_out == 8'h00)
    else $error("port defaults wrong after reset");
  a_int_power: assert property ($rose(nrst_in) |=> int_oe_out == |(~$past(port_in)))
    else $error("power-up pin compare wrong");
  // Both open-drain outputs may only ever pull low.
  a_int_drain: assert property (int_n_out == 1'b0)
    else $error("interrupt drives high");
  a_sda_drain: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  // Ack and read bits move only while the serial clock is low.
  a_ack_slot: assert property ($changed(sda_oe_out) |-> !scl_in && !$past(scl_in))
    else $error("data drive changed with clock high");
  // Output pins cannot raise the interrupt.
  a_out_mask: assert property ($past(port_oe_out) == 8'hFF |-> !int_oe_out)
    else $error("interrupt from output pins");
  // A quiet-bus change on an input pin raises the interrupt next cycle.
  a_pin_change: assert property (port_oe_out == 8'h00 && $past(port_oe_out) == 8'h00
    && !int_oe_out && $changed(port_in) && scl_in && $past(scl_in) && $past(scl_in, 2)
    && $stable(sda_in) && $past(sda_in, 2) == sda_in |=> int_oe_out)
    else $error("pin change missed");
  // A stop with steady pins leaves the interrupt released.
  a_stop_clear: assert property ((scl_in && $past(scl_in) && $rose(sda_in) && $stable(port_in))
    ##1 $stable(port_in) [*3] |-> !int_oe_out)
    else $error("stop did not release interrupt");
endmodule : iox_expander_checker

bind iox_expander iox_expander_checker chk_u (.clock_in, .nrst_in, .addr_sel_in, .scl_in,
  .sda_in, .sda_out, .sda_oe_out, .port_in, .port_out, .port_oe_out, .int_n_out, .int_oe_out);

`default_nettype wire

/* dv/iox_expander_tb.sv */
// Self-checking bench for the port expander core.
// Assumes the host model in dv/ and the checker bound to the core.
`include "iox_defines.svh"
`default_nettype none

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); end end

module iox_expander_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [2:0] STRAP = 3'h5;
  logic       clock_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic [7:0] port_in = 8'hFF;
  logic       scl, pull, sda_oe, sda_o, int_n, int_oe, sda_line;
  logic [7:0] port_out, port_oe;
  int         miscompares = 0;
  int         check_count = 0;

  // Released data line reads high through the pull-up.
  assign sda_line = !(pull | sda_oe);
  always #5 clock_in = !clock_in;

  iox_host_model host_u (.clock_in, .sda_line_in(sda_line), .scl_out(scl), .pull_out(pull));
  iox_expander dut_u (.clock_in, .nrst_in, .addr_sel_in(STRAP), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .port_in, .port_out, .port_oe_out(port_oe),
    .int_n_out(int_n), .int_oe_out(int_oe));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : cyc

  task automatic do_reset();
    nrst_in = 1'b0;
    cyc(4);
    nrst_in = 1'b1;
    cyc(2);
  endtask : do_reset

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // Addressed write: pointer, then nb data bits when nb is not zero.
  task automatic wr(input logic [7:0] ptr, input logic [7:0] dat, input int nb, input logic ak_e);
    logic [7:0] rx;
    logic       ak;
    host_u.frame_start();
    host_u.xfer({`IOX_ADDR_HI, STRAP, 1'b0}, 8, 1'b1, rx, ak);
    `CHK(ak, 1'b1)
    host_u.xfer(ptr, 8, 1'b1, rx, ak);
    if (nb > 0) begin
      host_u.xfer(dat, nb, 1'b1, rx, ak);
      `CHK(nb == 8 ? ak : sda_oe, ak_e)
    end
    host_u.frame_stop();
  endtask : wr

  task automatic t_reject();
    logic [7:0] rx;
    logic       ak;
    for (int i = 0; i < 2; i++) begin
      host_u.frame_start();
      host_u.xfer(i == 0 ? {4'h5, STRAP, 1'b0} : {`IOX_ADDR_HI, ~STRAP, 1'b0}, 8, 1'b1, rx, ak);
      `CHK(ak, 1'b0)
      host_u.frame_stop();
    end
    $display("test reject done");
  endtask : t_reject

  // A clipped byte must leave the latch alone.
  task automatic t_write();
    wr(8'h01, 8'hA5, 8, 1'b1);
    `CHK(port_out, 8'hA5)
    wr(8'h01, 8'h3C, 5, 1'b0);
    `CHK(port_out, 8'hA5)
    wr(8'h02, 8'h00, 8, 1'b1);
    `CHK(port_oe, 8'hFF)
    port_in = 8'h00;
    cyc(4);
    `CHK(int_oe, 1'b0)
    port_in = 8'hFF;
    wr(8'h02, 8'hFF, 8, 1'b1);
    $display("test write done");
  endtask : t_write

  task automatic t_intr();
    logic [7:0] rx;
    logic       ak;
    wr(8'h00, 8'h00, 0, 1'b1);
    port_in = 8'hF7;
    cyc(3);
    `CHK(int_oe, 1'b1)
    port_in = 8'hFF;
    cyc(3);
    `CHK(int_oe, 1'b0)
    port_in = 8'hF7;
    host_u.frame_start();
    host_u.xfer({`IOX_ADDR_HI, STRAP, 1'b1}, 8, 1'b1, rx, ak);
    host_u.xfer(8'hFF, 8, 1'b1, rx, ak);
    `CHK(rx, 8'hF7)
    `CHK(int_oe, 1'b0)
    // Pins move before the stop: the compare now runs against the read value.
    port_in = 8'hFF;
    cyc(3);
    `CHK(int_oe, 1'b1)
    host_u.frame_stop();
    `CHK(int_oe, 1'b0)
    $display("test interrupt done");
  endtask : t_intr

  // Mid-run reset with low pins: defaults return and the compare fires at once.
  task automatic t_reset();
    wr(8'h01, 8'h55, 8, 1'b1);
    port_in = 8'h7E;
    do_reset();
    `CHK({port_out, port_oe}, 16'hFF00)
    `CHK(int_oe, 1'b1)
    port_in = 8'hFF;
    cyc(3);
    `CHK(int_oe, 1'b0)
    $display("test reset done");
  endtask : t_reset

  // Power-up defaults with all pins high: no interrupt.
  task automatic t_defaults();
    do_reset();
    `CHK({port_out, port_oe, int_oe}, 17'h1FE00)
    `CHK({int_n, sda_o}, 2'b00)
    $display("test defaults done");
  endtask : t_defaults

  initial begin
    t_defaults();
    t_reject();
    t_write();
    t_intr();
    t_reset();
    close_out();
  end

  // A hang counts as a mismatch and still reaches the verdict.
  initial begin
    repeat (90000) @(posedge clock_in);
    miscompares++;
    close_out();
  end
endmodule : iox_expander_tb

`default_nettype wire

/* dv/iox_host_model.sv */
// Behavioural two-wire bus master for the port expander bench.
// Assumes a pull-up on the data line outside, sampled as sda_line_in.
`default_nettype none

module iox_host_model (
  // Clock and bus lines.
  input  wire logic clock_in,
  input  wire logic sda_line_in,
  output var logic  scl_out,
  output var logic  pull_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus: clock high, data released to the pull-up.
  initial begin
    scl_out = 1'b1;
    pull_out = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : cyc

  // Data moves only while the clock is low, three cycles clear of each edge.
  task automatic bit_io(input logic b, output logic r);
    scl_out = 1'b0;
    cyc(3);
    pull_out = !b;
    cyc(3);
    scl_out = 1'b1;
    cyc(3);
    r = sda_line_in;
    cyc(3);
  endtask : bit_io

  // Start or repeated start; every access opens with one.
  task automatic frame_start();
    logic r;
    bit_io(1'b1, r);
    pull_out = 1'b1;
    cyc(6);
  endtask : frame_start

  // Stop: data rises while the clock is high.
  task automatic frame_stop();
    logic r;
    bit_io(1'b0, r);
    pull_out = 1'b0;
    cyc(6);
  endtask : frame_stop

  // Sends nb bits MSB first; only a whole byte gets its ack slot.
  task automatic xfer(input logic [7:0] tx, input int nb, input logic last,
                      output logic [7:0] rx, output logic acked);
    logic r;
    rx = 8'h00;
    acked = 1'b0;
    for (int i = 7; i > 7 - nb; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    if (nb == 8) begin
      bit_io(last, r);
      acked = !r;
    end
  endtask : xfer
endmodule : iox_host_model

`default_nettype wire

/* shared/iox_defines.svh */
// Constants for the two-wire port expander: slave address, command
// pointers, reset values and bit counts.
// Assumes inclusion by every file of the expander core and its bench.
`ifndef IOX_DEFINES_SVH
`define IOX_DEFINES_SVH

// Upper four bits of the 7-bit slave address; the low three come from straps.
`define IOX_ADDR_HI     4'h4
// Command pointer values carried by the first written byte.
`define IOX_PTR_INPUT   8'h00
`define IOX_PTR_OUTPUT  8'h01
`define IOX_PTR_DIR     8'h02
// Reset values: direction one means input.
`define IOX_IN_RST      8'hFF
`define IOX_OUT_RST     8'hFF
`define IOX_DIR_RST     8'hFF
`define IOX_PTR_RST     8'h00
// Bits per byte on the serial bus.
`define IOX_BYTE_BITS   4'h8

`endif

/* shared/iox_pkg.sv */
// Types shared by the port expander core and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package iox_pkg;

  // Serial slave sequence states.
  typedef enum logic [2:0] {
    IOX_IDLE,
    IOX_ADDR,
    IOX_ACK_ADDR,
    IOX_WRITE,
    IOX_ACK_WRITE,
    IOX_READ,
    IOX_ACK_READ
  } iox_state_e;

  // One sample of the two bus lines.
  typedef struct packed {
    logic scl;
    logic sda;
  } iox_bus_s;

endpackage : iox_pkg

`default_nettype wire
